/* common/cme_consts.vh */
// Constants for the coprocessor mode, interrupt and exception state block.
// Assumes a 32-bit APB register window and a single core clock.
`ifndef CME_CONSTS_VH
`define CME_CONSTS_VH
// APB byte offsets (word aligned).
`define CME_OFF_KEY_LO 12'h000
`define CME_OFF_KEY_HI 12'h004
`define CME_OFF_MODE 12'h008
`define CME_OFF_IRQCTL 12'h00c
`define CME_OFF_SHADOW 12'h010
`define CME_OFF_REASON 12'h014
`define CME_OFF_STATUS 12'h018
// Key register field layout.
`define CME_TAG_MSB 7
`define CME_VPP_LSB 13
`define CME_VPP_MSB 47
`define CME_REG_LSB 62
`define CME_REG_MSB 63
// Region codes.
`define CME_REG_USER 2'b00
`define CME_REG_SUPER 2'b01
`define CME_REG_KERNEL 2'b11
// Mode register layout and reset.
`define CME_MODE_RESET 32'h30c0_00e4
`define CME_MODE_WMASK 32'hf4f0_ffff
`define CME_CU_LSB 28
`define CME_PX 23
`define CME_BEV 22
`define CME_SRST 20
`define CME_NMI 19
`define CME_IM_LSB 8
`define CME_KX 7
`define CME_SX 6
`define CME_UX 5
`define CME_PRIV_LSB 3
`define CME_ERL 2
`define CME_EXL 1
`define CME_IE 0
`define CME_PRIV_USER 2'b10
`define CME_PRIV_SUPER 2'b01
// Interrupt control.
`define CME_IRQCTL_ONES 32'hfc00_0000
`define CME_VS_LSB 5
`define CME_VS_MSB 9
// Reason register layout.
`define CME_BD 31
`define CME_TI 30
`define CME_CE_LSB 28
`define CME_DC 27
`define CME_PCI 26
`define CME_IV 23
`define CME_IP_LSB 8
`define CME_EXC_LSB 2
`define CME_REASON_WMASK 32'h0880_0300
// Cause codes.
`define CME_EXC_INT 5'h00
`define CME_EXC_MOD 5'h01
`define CME_EXC_TLB_LOAD_MISS_EXC 5'h02
`define CME_EXC_TLB_STORE_MISS_EXC 5'h03
`define CME_EXC_ADDR_ERR_LOAD_EXC 5'h04
`define CME_EXC_ADDR_ERR_STORE_EXC 5'h05
`define CME_EXC_CPU 5'h0b
// Vector offsets.
`define CME_VEC_GENERAL 12'h180
`define CME_VEC_SPECIAL 12'h200
`define CME_VEC_REFILL 12'h000
`define CME_VEC_XREFILL 12'h080
`define CME_TIMER_LINE 7
`endif

/* rtl/cme_state.v */
// Coprocessor mode, interrupt and exception state registers with an APB port.
// Assumes the pipeline presents exceptions as one-cycle pulses in clk_sys.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "cme_consts.vh"
//Behaviour
//- Key register holds 8-bit tag, 35-bit page pair, zero field, 2-bit region.
//- Region codes user 00, supervisor 01, kernel 11, matched to VA 63:62.
//- TLB refill, invalid or modified exceptions load page pair and region; tag is kept.
//- Eight mask bits gate eight pending lines; both set to take one.
//- Four usable bits; coprocessor 0 always usable in kernel mode.
//- User 64-bit ops allowed when ops bit set, else by user wide bit.
//- Wide addressing bits enable 64-bit segments and pick the wide refill vector.
//- Hardware sets the NMI flag; software cannot write it 0 to 1.
//- Soft-reset flag set to 1 on a soft reset exception.
//- Error level set on reset, soft reset, NMI or cache error.
//- Exception level set on all other exceptions.
//- Interrupts accepted only with global enable and both level bits clear.
//- Privilege 10 user, 01 supervisor with levels clear, else kernel.
//- Mode register resets to 0x30c000e4.
//- Vector spacing codes 0,1,2,4,8,0x10 map to 0..0x200.
//- Shadow bank fields always read zero.
//- Delay-slot bit records whether the exception was in a delay slot.
//- Unusable coprocessor number recorded on coprocessor unavailable.
//- Timer and performance counter pending shown as 1 in their bits.
//- Interrupt vector 0x180 when dedicated bit clear, 0x200 when set.
//- Pending bits follow sources; two lowest are software set and clear.
//- Cause codes 0 int, 1 mod, 2/3 TLB load/store, 4/5 address errors.
//- Count equal to compare raises the timer pending and line 7.
module cme_state (
   // Clock and reset
   input wire clk_sys,
   input wire reset_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Exception events from the pipeline
   input wire exc_take,
   input wire [4:0] exc_code,
   input wire exc_in_delay_slot,
   input wire exc_tlb_fault,
   input wire [63:0] exc_vaddr,
   input wire [1:0] exc_cop_num,
   input wire exc_soft_reset,
   input wire exc_nmi,
   input wire exc_cache_err,
   input wire exc_return,
   // Interrupt sources
   input wire [5:0] hw_irq,
   input wire perf_irq,
   input wire [31:0] timer_count,
   input wire [31:0] timer_compare,
   input wire timer_compare_write,
   // Pipeline-facing state
   output wire [63:0] tlb_high_key,
   output wire [31:0] processor_mode_state,
   output wire [7:0] irq_accept,
   output wire irq_request,
   output wire [2:0] run_mode,
   output wire [3:0] cop_usable_now,
   output wire user_64bit_ok,
   output wire wide_refill_vector,
   output wire [11:0] irq_vector_offset,
   output wire [11:0] irq_vector_spacing
);
   localparam MODE_KERNEL = 3'b001;
   localparam MODE_SUPER = 3'b010;
   localparam MODE_USER = 3'b100;

   reg [7:0] address_space_tag;
   reg [34:0] virtual_page_pair;
   reg [1:0] region;
   reg [31:0] mode;
   reg [4:0] vector_spacing;
   reg in_delay_slot;
   reg clock_irq_pending;
   reg [1:0] unusable_cop;
   reg count_disable;
   reg dedicated_irq_vector_sel;
   reg [1:0] soft_irq;
   reg [4:0] cause_code;
   reg [2:0] next_run_mode;
   reg [11:0] spacing;
   wire wr;
   wire rd_hit;
   wire [7:0] pending_irq_lines;
   wire [31:0] exception_reason;
   wire [31:0] key_hi_word;
   wire [31:0] mode_wdata;
   wire reset_class;

   // The registers answer in the first access cycle, so the slave never stalls.
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;

   // One address compare per register, shared by the strobes and the error flag.
   wire hit_key_lo;
   wire hit_key_hi;
   wire hit_mode;
   wire hit_irqctl;
   wire hit_shadow;
   wire hit_reason;
   wire hit_status;
   assign hit_key_lo = (paddr == `CME_OFF_KEY_LO);
   assign hit_key_hi = (paddr == `CME_OFF_KEY_HI);
   assign hit_mode = (paddr == `CME_OFF_MODE);
   assign hit_irqctl = (paddr == `CME_OFF_IRQCTL);
   assign hit_shadow = (paddr == `CME_OFF_SHADOW);
   assign hit_reason = (paddr == `CME_OFF_REASON);
   assign hit_status = (paddr == `CME_OFF_STATUS);
   assign rd_hit = hit_key_lo | hit_key_hi | hit_mode | hit_irqctl | hit_shadow |
      hit_reason | hit_status;
   // Unmapped accesses are flagged but otherwise ignored.
   assign pslverr = psel & penable & ~rd_hit;

   // Write strobes, one per register that software may change.
   wire wr_key_lo;
   wire wr_key_hi;
   wire wr_mode;
   wire wr_irqctl;
   wire wr_reason;
   assign wr_key_lo = wr & hit_key_lo;
   assign wr_key_hi = wr & hit_key_hi;
   assign wr_mode = wr & hit_mode;
   assign wr_irqctl = wr & hit_irqctl;
   assign wr_reason = wr & hit_reason;

   // The key register is two words on the bus; its zero fields always read back 0.
   assign tlb_high_key = {region, 14'h0000, virtual_page_pair, 5'h00,
      address_space_tag};
   assign key_hi_word = tlb_high_key[63:32];
   assign processor_mode_state = mode;
   assign reset_class = exc_soft_reset | exc_nmi | exc_cache_err;

   // Named views of the mode register fields.
   wire mode_ie;
   wire mode_exl;
   wire mode_erl;
   wire [1:0] mode_priv;
   wire [7:0] mode_im;
   wire mode_kx;
   wire mode_sx;
   wire mode_ux;
   wire mode_px;
   wire [3:0] mode_cu;
   wire any_level;
   wire irq_gate_open;
   assign mode_ie = mode[`CME_IE];
   assign mode_exl = mode[`CME_EXL];
   assign mode_erl = mode[`CME_ERL];
   assign mode_priv = mode[`CME_PRIV_LSB +: 2];
   assign mode_im = mode[`CME_IM_LSB +: 8];
   assign mode_kx = mode[`CME_KX];
   assign mode_sx = mode[`CME_SX];
   assign mode_ux = mode[`CME_UX];
   assign mode_px = mode[`CME_PX];
   assign mode_cu = mode[`CME_CU_LSB +: 4];
   assign any_level = mode_exl | mode_erl;
   assign irq_gate_open = mode_ie & ~any_level;

   // Line 7 is shared by the timer, the performance counter and the top hardware line;
   // the timer part stays latched until the compare value is rewritten.
   wire timer_line;
   wire [7:0] hw_lines;
   wire [7:0] sw_lines;
   assign timer_line = clock_irq_pending | perf_irq | hw_irq[5];
   assign hw_lines = {timer_line, hw_irq[4:0], 2'h0};
   assign sw_lines = {6'h00, soft_irq};
   assign pending_irq_lines = hw_lines | sw_lines;

   // Reason register, upper half then lower half.
   wire [15:0] reason_hi;
   wire [15:0] reason_lo;
   assign reason_hi = {in_delay_slot, clock_irq_pending, unusable_cop, count_disable,
      perf_irq, 2'h0, dedicated_irq_vector_sel, 7'h00};
   assign reason_lo = {pending_irq_lines, 1'b0, cause_code, 2'h0};
   assign exception_reason = {reason_hi, reason_lo};

   // A source is taken only when its mask bit and its pending bit are both set.
   wire [7:0] irq_enabled;
   assign irq_enabled = mode_im & pending_irq_lines;
   assign irq_accept = irq_gate_open ? irq_enabled : 8'h00;
   assign irq_request = |irq_accept;

   // Kernel when privilege 00 or either level bit set; the unused code 11 also
   // falls to kernel, so a bad write can never grant fewer checks than intended.
   always @* begin
      next_run_mode = MODE_KERNEL;
      if (!any_level) begin
         case (mode_priv)
            `CME_PRIV_USER: begin
               next_run_mode = MODE_USER;
            end
            `CME_PRIV_SUPER: begin
               next_run_mode = MODE_SUPER;
            end
            default: begin
               next_run_mode = MODE_KERNEL;
            end
         endcase
      end
   end
   assign run_mode = next_run_mode;

   // Coprocessor 0 is forced usable in kernel mode whatever its usable bit holds.
   assign cop_usable_now = mode_cu | {3'h0, next_run_mode == MODE_KERNEL};
   assign user_64bit_ok = mode_px | mode_ux;

   // The refill vector follows the wide bit of the mode being run.
   assign wide_refill_vector = (next_run_mode == MODE_USER) ? mode_ux :
      (next_run_mode == MODE_SUPER) ? mode_sx : mode_kx;

   // Only the listed spacing codes give a spacing; any other code gives none.
   function [11:0] spacing_of;
      input [4:0] code;
      begin
         case (code)
            5'h01: begin
               spacing_of = 12'h020;
            end
            5'h02: begin
               spacing_of = 12'h040;
            end
            5'h04: begin
               spacing_of = 12'h080;
            end
            5'h08: begin
               spacing_of = 12'h100;
            end
            5'h10: begin
               spacing_of = 12'h200;
            end
            default: begin
               spacing_of = 12'h000;
            end
         endcase
      end
   endfunction

   always @* begin
      spacing = spacing_of(vector_spacing);
   end
   assign irq_vector_spacing = spacing;
   assign irq_vector_offset = dedicated_irq_vector_sel ? `CME_VEC_SPECIAL :
      `CME_VEC_GENERAL;

   // NMI flag may be cleared but never set by software.
   wire [31:0] nmi_bit;
   wire [31:0] keep_nmi;
   assign nmi_bit = 32'h0000_0001 << `CME_NMI;
   assign keep_nmi = pwdata & mode & nmi_bit;
   assign mode_wdata = (pwdata & `CME_MODE_WMASK & ~nmi_bit) | keep_nmi;

   // Key register: exception load takes priority; a software write in the same cycle is dropped.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         address_space_tag <= 8'h00;
         virtual_page_pair <= 35'h0_0000_0000;
         region <= 2'b00;
      end else if (exc_take & exc_tlb_fault) begin
         virtual_page_pair <= exc_vaddr[`CME_VPP_MSB:`CME_VPP_LSB];
         region <= exc_vaddr[`CME_REG_MSB:`CME_REG_LSB];
      end else if (wr_key_lo) begin
         address_space_tag <= pwdata[`CME_TAG_MSB:0];
         virtual_page_pair[18:0] <= pwdata[31:`CME_VPP_LSB];
      end else if (wr_key_hi) begin
         virtual_page_pair[34:19] <= pwdata[15:0];
         region <= pwdata[31:30];
      end
   end

   // Mode register.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= `CME_MODE_RESET;
      end else if (exc_take | reset_class) begin
         if (exc_soft_reset) begin
            mode[`CME_SRST] <= 1'b1;
         end
         if (exc_nmi) begin
            mode[`CME_NMI] <= 1'b1;
         end
         if (reset_class) begin
            mode[`CME_ERL] <= 1'b1;
         end
         if (exc_take & ~reset_class) begin
            mode[`CME_EXL] <= 1'b1;
         end
      end else if (exc_return) begin
         if (mode[`CME_ERL]) begin
            mode[`CME_ERL] <= 1'b0;
         end else begin
            mode[`CME_EXL] <= 1'b0;
         end
      end else if (wr_mode) begin
         mode <= mode_wdata;
      end
   end

   // Interrupt control and reason registers.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         vector_spacing <= 5'h00;
         in_delay_slot <= 1'b0;
         clock_irq_pending <= 1'b0;
         unusable_cop <= 2'b00;
         count_disable <= 1'b0;
         dedicated_irq_vector_sel <= 1'b0;
         soft_irq <= 2'b00;
         cause_code <= `CME_EXC_INT;
      end else begin
         if (wr_irqctl) begin
            vector_spacing <= pwdata[`CME_VS_MSB:`CME_VS_LSB];
         end
         if (timer_count == timer_compare) begin
            clock_irq_pending <= 1'b1;
         end else if (timer_compare_write) begin
            clock_irq_pending <= 1'b0;
         end
         if (wr_reason) begin
            count_disable <= pwdata[`CME_DC];
            dedicated_irq_vector_sel <= pwdata[`CME_IV];
            soft_irq <= pwdata[`CME_IP_LSB +: 2];
         end
         if (exc_take) begin
            in_delay_slot <= exc_in_delay_slot;
            cause_code <= exc_code;
            if (exc_code == `CME_EXC_CPU) begin
               unusable_cop <= exc_cop_num;
            end
         end
      end
   end

   // Read mux; the shadow register always reads zero. Reads have no side effects,
   // so the mux may follow paddr in both bus phases.
   always @* begin
      case (paddr)
         `CME_OFF_KEY_LO: begin
            prdata = tlb_high_key[31:0];
         end
         `CME_OFF_KEY_HI: begin
            prdata = key_hi_word;
         end
         `CME_OFF_MODE: begin
            prdata = mode;
         end
         `CME_OFF_IRQCTL: begin
            prdata = `CME_IRQCTL_ONES |
               {22'h00_0000, vector_spacing, 5'h00};
         end
         `CME_OFF_SHADOW: begin
            prdata = 32'h0000_0000;
         end
         `CME_OFF_REASON: begin
            prdata = exception_reason;
         end
         `CME_OFF_STATUS: begin
            prdata = {25'h000_0000, cop_usable_now[0], user_64bit_ok,
               wide_refill_vector, irq_request, next_run_mode};
         end
         default: begin
            prdata = 32'h0000_0000;
         end
      endcase
   end
endmodule // cme_state

/* test/cme_state_asserts.sv */
// Port checker for the mode, interrupt and exception state block.
// Assumes one clk_sys domain and reset_n active low; bound to cme_state.
`timescale 1ns/1ps
module cme_state_asserts (
   // Clock and reset
   input wire clk_sys,
   input wire reset_n,
   // Pipeline events
   input wire exc_take,
   input wire exc_tlb_fault,
   input wire [63:0] exc_vaddr,
   input wire exc_nmi,
   input wire exc_soft_reset,
   input wire exc_cache_err,
   // State outputs
   input wire [63:0] tlb_high_key,
   input wire [31:0] processor_mode_state,
   input wire [7:0] irq_accept,
   input wire irq_request,
   input wire [2:0] run_mode,
   input wire [3:0] cop_usable_now
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire [31:0] m = processor_mode_state;
   wire [34:0] vpp = exc_vaddr[47:13];
   wire [7:0] tag = tlb_high_key[7:0];
   chk_reset_mode: assert property ($rose(reset_n) |-> m == 32'h30c0_00e4)
      else $error("mode value after reset is wrong");
   chk_key_load: assert property (exc_take && exc_tlb_fault |=>
      tlb_high_key[47:13] == $past(vpp) && tag == $past(tag))
      else $error("page pair not loaded on tlb fault");
   chk_irq_gate: assert property (irq_request |-> m[0] && m[2:1] == 2'b00)
      else $error("interrupt requested while disabled");
   chk_irq_mask: assert property ((irq_accept & ~m[15:8]) == 8'h00)
      else $error("masked interrupt accepted");
   chk_kernel_run: assert property (m[2:1] != 2'b00 || m[4:3] == 2'b00 |-> run_mode == 3'b001)
      else $error("not in kernel mode");
   chk_user_run: assert property (m[4:3] == 2'b10 && m[2:1] == 2'b00 |-> run_mode == 3'b100)
      else $error("not in user mode");
   chk_cu0_kernel: assert property (run_mode[0] |-> cop_usable_now[0])
      else $error("coprocessor 0 unusable in kernel mode");
   chk_erl_set: assert property (exc_nmi || exc_soft_reset || exc_cache_err |=> m[2])
      else $error("error level not set");
   chk_exl_set: assert property (exc_take && !(exc_nmi || exc_soft_reset || exc_cache_err) |=> m[1])
      else $error("exception level not set");
   chk_nmi_flag: assert property (exc_nmi |=> m[19])
      else $error("nmi flag not set");
   chk_srst_flag: assert property (exc_soft_reset |=> m[20])
      else $error("soft reset flag not set");
endmodule // cme_state_asserts
bind cme_state cme_state_asserts i_cme_state_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
   .exc_take(exc_take), .exc_tlb_fault(exc_tlb_fault), .exc_vaddr(exc_vaddr), .exc_nmi(exc_nmi),
   .exc_soft_reset(exc_soft_reset), .exc_cache_err(exc_cache_err), .tlb_high_key(tlb_high_key),
   .processor_mode_state(processor_mode_state), .irq_accept(irq_accept),
   .irq_request(irq_request), .run_mode(run_mode), .cop_usable_now(cop_usable_now));

/* test/cme_pipe_model.sv */
// Pipeline model that raises taken exceptions as one-cycle pulses.
// Assumes its fault task is called just after a rising clk_sys edge.
`timescale 1ns/1ps
module cme_pipe_model (
   // Clock
   input wire clk_sys,
   // Exception event
   output reg exc_take,
   output reg [4:0] exc_code,
   output reg exc_in_delay_slot,
   output reg exc_tlb_fault,
   output reg [63:0] exc_vaddr,
   output reg [1:0] exc_cop_num
);
   initial begin
      {exc_take, exc_code, exc_in_delay_slot, exc_tlb_fault, exc_vaddr, exc_cop_num} = 0;
   end
   // Qualifiers turn to junk after the pulse, the TLB fault flag to 0, so stale values cannot be relied on.
   task fault(input [4:0] c, input [63:0] va, input ds, input tf, input [1:0] cp);
      begin
         exc_take <= 1; exc_code <= c; exc_vaddr <= va;
         exc_in_delay_slot <= ds; exc_tlb_fault <= tf; exc_cop_num <= cp;
         @(posedge clk_sys) exc_take <= 0;
         exc_code <= ~c; exc_vaddr <= ~va; exc_in_delay_slot <= ~ds;
         exc_tlb_fault <= 0; exc_cop_num <= ~cp;
         @(posedge clk_sys);
      end
   endtask
endmodule // cme_pipe_model

/* test/cme_state_tb.sv */
// Self-checking bench for the mode, interrupt and exception state block.
// Assumes a zero-wait APB slave; the pipeline model raises exceptions.
`timescale 1ns/1ps
module cme_state_tb;
   reg clk_sys, reset_n, psel, penable, pwrite, e, perf_irq, timer_compare_write;
   reg exc_soft_reset, exc_nmi, exc_cache_err, exc_return;
   reg [11:0] paddr;
   reg [31:0] pwdata, d, timer_count, timer_compare;
   reg [5:0] hw_irq;
   reg [63:0] v;
   wire pready, pslverr, exc_take, ds, tf, req, u64, wide;
   wire [31:0] prdata, mode;
   wire [4:0] code;
   wire [63:0] va, key;
   wire [1:0] cop;
   wire [7:0] acc;
   wire [2:0] rm;
   wire [3:0] cu;
   wire [11:0] voff, vsp;
   integer errors = 0, n_compared = 0, cyc = 0, i;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
   cme_state i_cme_state (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .exc_take(exc_take), .exc_code(code),
      .exc_in_delay_slot(ds), .exc_tlb_fault(tf), .exc_vaddr(va), .exc_cop_num(cop),
      .exc_soft_reset(exc_soft_reset), .exc_nmi(exc_nmi), .exc_cache_err(exc_cache_err),
      .exc_return(exc_return), .hw_irq(hw_irq), .perf_irq(perf_irq),
      .timer_count(timer_count), .timer_compare(timer_compare),
      .timer_compare_write(timer_compare_write), .tlb_high_key(key),
      .processor_mode_state(mode), .irq_accept(acc), .irq_request(req), .run_mode(rm),
      .cop_usable_now(cu), .user_64bit_ok(u64), .wide_refill_vector(wide),
      .irq_vector_offset(voff), .irq_vector_spacing(vsp));
   cme_pipe_model i_cme_pipe_model (.clk_sys(clk_sys), .exc_take(exc_take),
      .exc_code(code), .exc_in_delay_slot(ds), .exc_tlb_fault(tf), .exc_vaddr(va),
      .exc_cop_num(cop));
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (++cyc > 2000) begin
      errors++;
      complete_run;
   end
   task complete_run;
      begin
         $display("compared %0d errors %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   // One APB transfer; an idle cycle follows so psel is never driven twice in one step.
   task xf(input w, input [11:0] a, input [31:0] wd);
      begin
         psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
         @(posedge clk_sys) penable <= 1;
         @(posedge clk_sys) while (!pready) @(posedge clk_sys);
         d = prdata; e = pslverr; psel <= 0; penable <= 0;
         @(posedge clk_sys);
      end
   endtask
   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata, hw_irq, perf_irq, exc_return} = 0;
      {timer_compare_write, exc_soft_reset, exc_nmi, exc_cache_err, timer_count} = 0;
      timer_compare = 32'h0000_0001;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1;
      @(posedge clk_sys);
      xf(0, 12'h008, 0); `CHK(d, 32'h30c0_00e4)
      xf(0, 12'h010, 0); `CHK(d, 32'h0000_0000)
      xf(0, 12'h01c, 0); `CHK(e, 1'b1)
      xf(1, 12'h000, 32'hffff_ffff); xf(1, 12'h004, 32'hffff_ffff);
      `CHK(key, 64'hc000_ffff_ffff_e0ff)
      for (i = 0; i < 6; i++) begin
         v = 64'h4000_abcd_1234_6000 ^ (i << 13);
         i_cme_pipe_model.fault(i, v, i[0], i > 0 && i < 4, 2'd0);
         xf(0, 12'h014, 0); `CHK({d[31], d[6:2]}, {i[0], i[4:0]})
         if (i > 0 && i < 4) `CHK(key[47:0], {v[47:13], 13'h00ff})
      end
      i_cme_pipe_model.fault(5'd11, 64'h0, 1'b0, 1'b0, 2'd2);
      xf(0, 12'h014, 0); `CHK(d[29:28], 2'd2)
      xf(1, 12'h008, 32'h2000_0010); `CHK(cu, 4'b0010)
      xf(1, 12'h008, 32'h2000_0000); `CHK(cu, 4'b0011)
      xf(0, 12'h018, 0); `CHK(d, 32'h0000_0041)
      `CHK(pready, 1'b1)
      xf(1, 12'h008, 32'h3000_0111); `CHK(rm, 3'b100)
      xf(1, 12'h014, 32'h0000_0100); `CHK({req, acc}, 9'h101)
      xf(1, 12'h008, 32'h3000_0209); `CHK({req, rm}, 4'b0010)
      xf(1, 12'h008, 32'h3000_0103); `CHK({req, rm}, 4'b0001)
      hw_irq <= 6'h01; perf_irq <= 1; timer_count <= 1;
      @(posedge clk_sys) timer_count <= 2;
      xf(0, 12'h014, 0); `CHK({d[30], d[26], d[15:8]}, 10'h385)
      hw_irq <= 0; perf_irq <= 0; timer_compare_write <= 1;
      @(posedge clk_sys) timer_compare_write <= 0;
      xf(0, 12'h014, 0); `CHK({d[30], d[26], d[15:8]}, 10'h001)
      `CHK(voff, 12'h180)
      xf(1, 12'h014, 32'h0080_0100); `CHK(voff, 12'h200)
      for (i = 0; i < 6; i++) begin
         xf(1, 12'h00c, (i ? 1 << (i - 1) : 0) << 5);
         `CHK(vsp, (i ? 12'h020 << (i - 1) : 12'h000))
      end
      xf(1, 12'h008, 32'h3080_0010); `CHK({u64, wide}, 2'b10)
      xf(1, 12'h008, 32'h3000_0030); `CHK({u64, wide}, 2'b11)
      xf(1, 12'h008, 32'h3000_0010); `CHK({u64, wide}, 2'b00)
      xf(1, 12'h008, 32'h3008_0080); `CHK({mode[19], wide}, 2'b01)
      exc_cache_err <= 1; @(posedge clk_sys) exc_cache_err <= 0; @(posedge clk_sys);
      `CHK(mode[2], 1'b1)
      exc_nmi <= 1; @(posedge clk_sys) exc_nmi <= 0; @(posedge clk_sys);
      exc_soft_reset <= 1; @(posedge clk_sys) exc_soft_reset <= 0; @(posedge clk_sys);
      `CHK(mode[20:19], 2'b11)
      exc_return <= 1; @(posedge clk_sys) exc_return <= 0; @(posedge clk_sys);
      `CHK(mode[2], 1'b0)
      complete_run;
   end
endmodule // cme_state_tb
